// ### dv/lcd_link_properties.sv
module lcd_link_properties #(
  parameter int HOLD_CLKS = lcd_link_pkg::SHUT_HOLD_CLKS,
  parameter int SCLK_HALF = lcd_link_pkg::SCLK_HALF_CLKS
) (
  // Host clock domain
  input wire logic core_clk,
  input wire logic reset,
  // Link
  input wire logic pixel_clock,
  input wire logic vertical_sync_pulse_n,
  input wire logic [lcd_link_pkg::PIXEL_BITS-1:0] pixel_data,
  input wire logic shutdown,
  input wire logic module_reset_n,
  input wire logic serial_select_n,
  input wire logic serial_clock,
  input wire logic serial_input
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEL_MIN = 18 * SCLK_HALF;
  localparam int SEL_MAX = 20 * SCLK_HALF;
  logic pclk_reg, pclk_next, sclk_reg, sclk_next;
  int falls_reg, falls_next, bits_reg, bits_next;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Falls count only while shutdown is seen high
  always_comb begin
    pclk_next = pixel_clock;
    sclk_next = serial_clock;
    falls_next = falls_reg;
    bits_next = bits_reg;
    if (reset || !shutdown)
      falls_next = 0;
    else if (pclk_reg && !pixel_clock)
      falls_next = falls_reg + 1;
    if (reset || serial_select_n)
      bits_next = 0;
    else if (!sclk_reg && serial_clock)
      bits_next = bits_reg + 1;
  end

  always_ff @(posedge core_clk) begin
    pclk_reg <= pclk_next;
    sclk_reg <= sclk_next;
    falls_reg <= falls_next;
    bits_reg <= bits_next;
  end

  // One fall of slack: falls_reg takes in each fall one core clock after the fall
  a_clock_running: assert property (
    shutdown && falls_reg < HOLD_CLKS - 1 |=> $changed(pixel_clock))
    else $error("pixel clock stopped inside the shutdown hold");
  a_clock_stops_low: assert property (
    !$changed(pixel_clock) |-> !pixel_clock)
    else $error("pixel clock held high");
  a_reset_after_wait: assert property (
    $fell(module_reset_n) |-> !shutdown || falls_reg >= HOLD_CLKS - 1)
    else $error("panel reset inside the shutdown hold");
  a_shutdown_held: assert property (
    shutdown && falls_reg < HOLD_CLKS - 1 |=> shutdown)
    else $error("shutdown dropped before two frames");
  a_clock_in_frame: assert property (
    serial_select_n |-> !serial_clock)
    else $error("serial clock pulse outside select");
  a_select_length: assert property (
    $fell(serial_select_n) |-> ##[SEL_MIN:SEL_MAX] $rose(serial_select_n))
    else $error("select low for a wrong time");
  a_nine_bits: assert property (
    $rose(serial_select_n) |-> bits_reg == 9)
    else $error("serial word not nine bits");
  a_bit_held: assert property (
    serial_clock |-> $stable(serial_input))
    else $error("serial input moved while clock high");
  a_blank_in_sync: assert property (
    !vertical_sync_pulse_n |-> pixel_data == 18'h00000)
    else $error("pixel data not black in sync line");
  a_data_held: assert property (
    pixel_clock |-> $stable(pixel_data))
    else $error("pixel data moved while pixel clock high");
endmodule

// ### dv/lcd_module_host_interface_bench.sv
module lcd_module_host_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINES = 4;
  localparam int HOLD = 2 * lcd_link_pkg::LINE_CLKS * LINES;
  localparam int ON_N = 3;
  localparam int H = lcd_link_pkg::SCLK_HALF_CLKS;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic dev_reset = 1'b1;
  logic shutdown_req = 1'b0;
  logic module_reset_req = 1'b0;
  logic [5:0] red_in = 6'h00, green_in = 6'h00, blue_in = 6'h00;
  logic setup_start = 1'b0;
  logic flag = 1'b0;
  logic [7:0] payload = 8'h00;
  logic link_stopped, setup_ready, display_on, pixel_black, pixel_white;
  logic [5:0] red_out, green_out, blue_out;
  logic setup_valid, rx_flag;
  logic [7:0] rx_payload;
  logic [8:0] cap_word;
  logic pc_last = 1'b0;
  bit rst_in_wait;
  int cap_bits, falls, low_run, pulse_len, cycles, mismatches, total_checks;

  lcd_link_if link();
  always #50 core_clk = ~core_clk;

  host_display_end #(.FRAME_LINES(LINES), .HOLD_CLKS(HOLD), .SCLK_HALF(H))
    host_display_end_i (.core_clk(core_clk), .reset(reset),
    .shutdown_req(shutdown_req), .module_reset_req(module_reset_req),
    .link_stopped(link_stopped), .red_in(red_in), .green_in(green_in),
    .blue_in(blue_in), .setup_start(setup_start),
    .setup_command_data_flag(flag), .setup_payload(payload),
    .setup_ready(setup_ready), .link(link));
  panel_device_end #(.ON_FALLS(ON_N)) panel_device_end_i (.reset(dev_reset),
    .display_on(display_on), .red_out(red_out), .green_out(green_out),
    .blue_out(blue_out), .pixel_black(pixel_black),
    .pixel_white(pixel_white), .setup_valid(setup_valid),
    .setup_command_data_flag(rx_flag), .setup_payload(rx_payload),
    .link(link));
  lcd_link_properties #(.HOLD_CLKS(HOLD), .SCLK_HALF(H))
    lcd_link_properties_i (.core_clk(core_clk), .reset(reset),
    .pixel_clock(link.pixel_clock),
    .vertical_sync_pulse_n(link.vertical_sync_pulse_n),
    .pixel_data(link.pixel_data), .shutdown(link.shutdown),
    .module_reset_n(link.module_reset_n),
    .serial_select_n(link.serial_select_n),
    .serial_clock(link.serial_clock), .serial_input(link.serial_input));

  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Link watched on the falling core edge, clear of every launch
  always @(negedge core_clk) begin
    falls = link.shutdown ? falls + (pc_last && !link.pixel_clock) : 0;
    pc_last = link.pixel_clock;
    if (link.shutdown && !link_stopped && !link.module_reset_n)
      rst_in_wait = 1'b1;
    if (!link.module_reset_n)
      low_run++;
    else if (low_run > 0) begin
      pulse_len = low_run;
      low_run = 0;
    end
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict();
    end
  end

  always @(negedge link.serial_select_n)
    cap_bits = 0;
  always @(posedge link.serial_clock)
    if (!link.serial_select_n) begin
      cap_word = {cap_word[7:0], link.serial_input};
      cap_bits++;
    end

  task automatic wait_vs(int n);
    repeat (n) @(negedge link.vertical_sync_pulse_n);
    repeat (8) @(negedge core_clk);
  endtask

  task automatic t_serial();
    logic [8:0] words [2] = '{9'h0a5, 9'h13c};
    foreach (words[k]) begin
      @(posedge core_clk);
      while (setup_ready !== 1'b1)
        @(posedge core_clk);
      setup_start <= 1'b1;
      {flag, payload} <= words[k];
      @(posedge core_clk);
      setup_start <= 1'b0;
      for (int i = 0; i < 400 && setup_valid !== 1'b1; i++)
        @(negedge core_clk);
      check("valid", setup_valid, 1'b1);
      check("flag", rx_flag, words[k][8]);
      check("payload", rx_payload, words[k][7:0]);
      check("wire bits", cap_bits, 9);
      check("wire word", cap_word, words[k]);
    end
  endtask

  task automatic t_pixels();
    // White, brightest red, blue 2a with green 20 and red 01, black
    logic [17:0] cols [4] = '{18'h3ffff, 18'h0003f, 18'h2a801, 18'h00000};
    foreach (cols[k]) begin
      @(posedge core_clk);
      {blue_in, green_in, red_in} <= cols[k];
      repeat (2 * lcd_link_pkg::LINE_CLKS) @(negedge core_clk);
      for (int i = 0; i < 4000 && pixel_black !== (cols[k] == 0); i++)
        @(negedge core_clk);
      check("red", red_out, cols[k][5:0]);
      check("green", green_out, cols[k][11:6]);
      check("blue", blue_out, cols[k][17:12]);
      check("white", pixel_white, cols[k] == 18'h3ffff);
      check("black", pixel_black, cols[k] == 18'h00000);
      check("wire", link.pixel_data, cols[k]);
    end
  endtask

  task automatic t_power();
    // Start just after a sync line so the falls are a frame apart
    @(posedge link.vertical_sync_pulse_n);
    @(posedge core_clk);
    shutdown_req <= 1'b1;
    module_reset_req <= 1'b1;
    pulse_len = 0;
    wait_vs(1);
    check("on after one fall", display_on, 1'b1);
    wait_vs(1);
    check("off after two falls", display_on, 1'b0);
    for (int i = 0; i < 2 * HOLD + 400 && link_stopped !== 1'b1; i++)
      @(negedge core_clk);
    // Let the link watcher count the final fall first
    @(negedge core_clk);
    check("hold", falls >= HOLD && falls <= HOLD + 1, 1'b1);
    check("clock low", link.pixel_clock, 1'b0);
    check("reset in wait", rst_in_wait, 1'b0);
    repeat (300) @(negedge core_clk);
    check("pulse", pulse_len, lcd_link_pkg::RESET_PULSE_CLKS);
    @(posedge core_clk);
    shutdown_req <= 1'b0;
    module_reset_req <= 1'b0;
    for (int i = 0; i < 100 && link.shutdown !== 1'b0; i++)
      @(negedge core_clk);
    repeat (8) @(negedge core_clk);
    wait_vs(ON_N - 1);
    check("dark early", display_on, 1'b0);
    wait_vs(1);
    check("back on", display_on, 1'b1);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (8) @(posedge core_clk);
    dev_reset <= 1'b0;
    for (int i = 0; i < 30000 && display_on !== 1'b1; i++)
      @(negedge core_clk);
    t_serial();
    t_pixels();
    t_power();
    give_verdict();
  end
endmodule

// ### hw/host_display_end.sv
module host_display_end #(
  parameter int LINE_CLKS = lcd_link_pkg::LINE_CLKS,
  parameter int FRAME_LINES = lcd_link_pkg::FRAME_LINES,
  parameter int HOLD_CLKS = lcd_link_pkg::SHUT_HOLD_CLKS,
  parameter int SCLK_HALF = lcd_link_pkg::SCLK_HALF_CLKS
) (
  // Clock and reset
  input logic core_clk,
  input logic reset,
  // Power control
  input logic shutdown_req,
  input logic module_reset_req,
  output logic link_stopped,
  // Pixel source, held by the user
  input logic [lcd_link_pkg::COLOUR_BITS-1:0] red_in,
  input logic [lcd_link_pkg::COLOUR_BITS-1:0] green_in,
  input logic [lcd_link_pkg::COLOUR_BITS-1:0] blue_in,
  // Setup word port
  input logic setup_start,
  input logic setup_command_data_flag,
  input logic [lcd_link_pkg::PAYLOAD_BITS-1:0] setup_payload,
  output logic setup_ready,
  // Display link
  lcd_link_if.host link
);
  localparam int PB = lcd_link_pkg::PAYLOAD_BITS;
  localparam int HW = $clog2(LINE_CLKS);
  localparam int VW = $clog2(FRAME_LINES);
  localparam int CW = $clog2(HOLD_CLKS + 1);
  localparam int TW = $clog2(SCLK_HALF + 1);
  localparam int RW = $clog2(lcd_link_pkg::RESET_PULSE_CLKS + 1);
  localparam int KW = $clog2(lcd_link_pkg::WORD_BITS);
  localparam logic [HW-1:0] H_LAST = HW'(LINE_CLKS - 1);
  localparam logic [VW-1:0] V_LAST = VW'(FRAME_LINES - 1);
  localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CLKS - 1);
  localparam logic [TW-1:0] HALF_LAST = TW'(SCLK_HALF - 1);
  localparam logic [RW-1:0] RESET_LEN = RW'(lcd_link_pkg::RESET_PULSE_CLKS);
  localparam logic [KW-1:0] LAST_BIT = KW'(lcd_link_pkg::WORD_BITS - 1);
  if (LINE_CLKS < lcd_link_pkg::H_BACK_PORCH + 1 ||
      FRAME_LINES < lcd_link_pkg::V_BACK_PORCH + 1 || HOLD_CLKS < 1 ||
      SCLK_HALF < lcd_link_pkg::SCLK_PHASE_MIN_CLKS ||
      SCLK_HALF < lcd_link_pkg::SCLK_SYNC_MIN_CLKS) begin : g_bad_params
    $error("host_display_end: parameters out of range");
  end
  typedef enum logic [1:0] {
    P_RUN = 2'b00,
    P_WAIT = 2'b01,
    P_STOP = 2'b10,
    P_WAKE = 2'b11
  } power_state_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_HIGH = 3'b010,
    S_END = 3'b011,
    S_GAP = 3'b100
  } serial_state_t;
  function automatic logic in_window(input int pos, input int first,
                                     input int count);
    return pos >= first && pos < first + count;
  endfunction
  // Pixel timing, power sequence and module reset pulse
  logic pclk_reg, pclk_next, fall_tick;
  logic [HW-1:0] h_reg, h_next;
  logic [VW-1:0] v_reg, v_next;
  logic vs_n_reg, vs_n_next, shut_reg, shut_next, stopped_next;
  logic [lcd_link_pkg::PIXEL_BITS-1:0] data_reg, data_next;
  power_state_t pwr_reg, pwr_next;
  logic [CW-1:0] hold_reg, hold_next;
  logic [RW-1:0] rst_cnt_reg, rst_cnt_next;
  logic served_reg, served_next, rst_n_reg, rst_n_next, rst_start;
  // Serial setup
  serial_state_t ser_reg, ser_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic [KW-1:0] bit_reg, bit_next;
  logic [PB:0] shift_reg, shift_next;
  logic sel_n_reg, sel_n_next, sclk_reg, sclk_next;
  logic sin_reg, sin_next, ready_next;
  // Data changes on the pixel clock fall, the panel samples on the rise
  assign fall_tick = pclk_reg;
  always_comb begin
    pclk_next = (pwr_reg != P_STOP) ? !pclk_reg : 1'b0;
    h_next = h_reg;
    v_next = v_reg;
    vs_n_next = vs_n_reg;
    data_next = data_reg;
    if (fall_tick) begin
      h_next = (h_reg == H_LAST) ? '0 : HW'(h_reg + 1'b1);
      if (h_reg == H_LAST) begin
        v_next = (v_reg == V_LAST) ? '0 : VW'(v_reg + 1'b1);
      end
      vs_n_next = v_next != '0;
      data_next = '0;
      if (in_window(int'(h_next), lcd_link_pkg::H_BACK_PORCH,
                    lcd_link_pkg::H_DISPLAY) &&
          in_window(int'(v_next), lcd_link_pkg::V_BACK_PORCH,
                    lcd_link_pkg::V_DISPLAY)) begin
        data_next = {blue_in, green_in, red_in};
      end
    end
  end
  always_comb begin
    pwr_next = pwr_reg;
    hold_next = hold_reg;
    unique case (pwr_reg)
      P_RUN: begin
        if (shutdown_req) begin
          pwr_next = P_WAIT;
          hold_next = '0;
        end
      end
      P_WAIT: begin
        // The clock may stop only on a fall, so it halts low
        if (fall_tick) begin
          if (hold_reg == HOLD_LAST) begin
            pwr_next = P_STOP;
          end else begin
            hold_next = CW'(hold_reg + 1'b1);
          end
        end
      end
      P_STOP: begin
        if (!shutdown_req) begin
          pwr_next = P_WAKE;
        end
      end
      P_WAKE: begin
        if (fall_tick) begin
          pwr_next = P_RUN;
        end
      end
    endcase
    shut_next = pwr_next != P_RUN;
    stopped_next = pwr_next == P_STOP;
  end
  // No reset pulse while the two-frame wait runs or is about to start
  assign rst_start = module_reset_req && !served_reg &&
    rst_cnt_reg == '0 && pwr_next != P_WAIT;
  always_comb begin
    rst_cnt_next = rst_start ? RESET_LEN :
      (rst_cnt_reg == '0) ? '0 : RW'(rst_cnt_reg - 1'b1);
    served_next = module_reset_req && (served_reg || rst_start);
    rst_n_next = rst_cnt_next == '0;
  end
  always_comb begin
    ser_next = ser_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    sel_n_next = sel_n_reg;
    sclk_next = sclk_reg;
    sin_next = sin_reg;
    timer_next = (timer_reg == '0) ? '0 : TW'(timer_reg - 1'b1);
    unique case (ser_reg)
      S_IDLE: begin
        if (setup_start) begin
          shift_next = {setup_command_data_flag, setup_payload};
          sin_next = setup_command_data_flag;
          sel_n_next = 1'b0;
          timer_next = HALF_LAST;
          bit_next = '0;
          ser_next = S_SETUP;
        end
      end
      S_SETUP: begin
        if (timer_reg == '0) begin
          sclk_next = 1'b1;
          timer_next = HALF_LAST;
          ser_next = S_HIGH;
        end
      end
      S_HIGH: begin
        if (timer_reg == '0) begin
          sclk_next = 1'b0;
          timer_next = HALF_LAST;
          if (bit_reg == LAST_BIT) begin
            ser_next = S_END;
          end else begin
            shift_next = {shift_reg[PB-1:0], 1'b0};
            sin_next = shift_reg[PB-1];
            bit_next = KW'(bit_reg + 1'b1);
            ser_next = S_SETUP;
          end
        end
      end
      S_END: begin
        if (timer_reg == '0) begin
          sel_n_next = 1'b1;
          timer_next = HALF_LAST;
          ser_next = S_GAP;
        end
      end
      S_GAP: begin
        if (timer_reg == '0) begin
          ser_next = S_IDLE;
        end
      end
      default: begin
        ser_next = S_IDLE;
        sel_n_next = 1'b1;
        sclk_next = 1'b0;
      end
    endcase
    ready_next = ser_next == S_IDLE;
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pclk_reg <= 1'b0;
      h_reg <= '0;
      v_reg <= '0;
      vs_n_reg <= 1'b1;
      data_reg <= '0;
      pwr_reg <= P_RUN;
      hold_reg <= '0;
      shut_reg <= 1'b0;
      link_stopped <= 1'b0;
      // A reset pulse follows every host reset to bring the panel up
      rst_cnt_reg <= RESET_LEN;
      served_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      ser_reg <= S_IDLE;
      timer_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
      sel_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      sin_reg <= 1'b0;
      setup_ready <= 1'b0;
    end else begin
      pclk_reg <= pclk_next;
      h_reg <= h_next;
      v_reg <= v_next;
      vs_n_reg <= vs_n_next;
      data_reg <= data_next;
      pwr_reg <= pwr_next;
      hold_reg <= hold_next;
      shut_reg <= shut_next;
      link_stopped <= stopped_next;
      rst_cnt_reg <= rst_cnt_next;
      served_reg <= served_next;
      rst_n_reg <= rst_n_next;
      ser_reg <= ser_next;
      timer_reg <= timer_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      sel_n_reg <= sel_n_next;
      sclk_reg <= sclk_next;
      sin_reg <= sin_next;
      setup_ready <= ready_next;
    end
  end
  assign link.pixel_clock = pclk_reg;
  assign link.vertical_sync_pulse_n = vs_n_reg;
  assign link.pixel_data = data_reg;
  assign link.shutdown = shut_reg;
  assign link.module_reset_n = rst_n_reg;
  // Write-only port: the host never listens on the serial lines
  assign link.serial_select_n = sel_n_reg;
  assign link.serial_clock = sclk_reg;
  assign link.serial_input = sin_reg;
endmodule

// ### hw/lcd_link_if.sv
interface lcd_link_if;
  logic pixel_clock;
  logic vertical_sync_pulse_n;
  logic [lcd_link_pkg::PIXEL_BITS-1:0] pixel_data;
  logic shutdown;
  logic module_reset_n;
  logic serial_select_n;
  logic serial_clock;
  logic serial_input;

  modport host (
    output pixel_clock,
    output vertical_sync_pulse_n,
    output pixel_data,
    output shutdown,
    output module_reset_n,
    output serial_select_n,
    output serial_clock,
    output serial_input
  );

  modport device (
    input pixel_clock,
    input vertical_sync_pulse_n,
    input pixel_data,
    input shutdown,
    input module_reset_n,
    input serial_select_n,
    input serial_clock,
    input serial_input
  );
endinterface

// ### hw/lcd_link_pkg.sv
package lcd_link_pkg;
  // Frame geometry in pixel clocks and lines
  localparam int LINE_CLKS = 336;
  localparam int FRAME_LINES = 244;
  localparam int H_BACK_PORCH = 8;
  localparam int H_DISPLAY = 320;
  localparam int V_BACK_PORCH = 2;
  localparam int V_DISPLAY = 240;
  // Power down: frames that the pixel clock must outlive shutdown
  localparam int SHUT_OFF_FRAMES = 2;
  localparam int SHUT_HOLD_CLKS = SHUT_OFF_FRAMES * LINE_CLKS * FRAME_LINES;
  // Vertical sync falling edges to blank and to restart the display
  localparam int OFF_FALLS = 2;
  localparam int ON_FALLS = 10;
  // Pixel word layout
  localparam int COLOUR_BITS = 6;
  localparam int PIXEL_BITS = 3 * COLOUR_BITS;
  localparam int RED_LSB = 0;
  localparam int GREEN_LSB = 6;
  localparam int BLUE_LSB = 12;
  localparam logic [COLOUR_BITS-1:0] DARKEST_LEVEL = 6'h00;
  localparam logic [COLOUR_BITS-1:0] BRIGHTEST_LEVEL = 6'h3f;
  // Serial setup word
  localparam int WORD_BITS = 9;
  localparam int PAYLOAD_BITS = 8;
  // Core clock and times derived from it
  localparam int CORE_PERIOD_NS = 100;
  localparam int RESET_PULSE_US = 10;
  localparam int RESET_PULSE_CLKS =
    (RESET_PULSE_US * 1000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SCLK_PHASE_MIN_NS = 25;
  localparam int SCLK_PHASE_MIN_CLKS =
    (SCLK_PHASE_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SCLK_HALF_CLKS = 8;
  // Device samples serial pins at pixel rate through two flops
  localparam int SCLK_SYNC_MIN_CLKS = 4;
endpackage

// ### hw/panel_device_end.sv
module panel_device_end #(
  parameter int OFF_FALLS = lcd_link_pkg::OFF_FALLS,
  parameter int ON_FALLS = lcd_link_pkg::ON_FALLS
) (
  // Reset, synchronous to the pixel clock
  input logic reset,
  // Display state and decoded pixel
  output logic display_on,
  output logic [lcd_link_pkg::COLOUR_BITS-1:0] red_out,
  output logic [lcd_link_pkg::COLOUR_BITS-1:0] green_out,
  output logic [lcd_link_pkg::COLOUR_BITS-1:0] blue_out,
  output logic pixel_black,
  output logic pixel_white,
  // Received setup word
  output logic setup_valid,
  output logic setup_command_data_flag,
  output logic [lcd_link_pkg::PAYLOAD_BITS-1:0] setup_payload,
  // Display link
  lcd_link_if.device link
);
  localparam int CB = lcd_link_pkg::COLOUR_BITS;
  localparam int PB = lcd_link_pkg::PAYLOAD_BITS;
  localparam int FW = $clog2(ON_FALLS + OFF_FALLS + 1);
  localparam int BW = $clog2(lcd_link_pkg::WORD_BITS + 2);
  localparam logic [BW-1:0] FULL_COUNT = BW'(lcd_link_pkg::WORD_BITS);
  localparam logic [BW-1:0] OVER_COUNT = BW'(lcd_link_pkg::WORD_BITS + 1);

  if (OFF_FALLS < 1 || ON_FALLS < 1) begin : g_bad_falls
    $error("panel_device_end: fall counts must be at least one");
  end

  typedef enum logic [1:0] {
    D_ON = 2'b00,
    D_ARMED = 2'b01,
    D_OFF = 2'b10,
    D_WAKE = 2'b11
  } display_state_t;

  function automatic logic all_channels(
    input logic [lcd_link_pkg::PIXEL_BITS-1:0] pix,
    input logic [CB-1:0] level);
    return pix[lcd_link_pkg::RED_LSB +: CB] == level &&
      pix[lcd_link_pkg::GREEN_LSB +: CB] == level &&
      pix[lcd_link_pkg::BLUE_LSB +: CB] == level;
  endfunction

  // Pins that are not timed to the pixel clock
  logic shut_s1_reg, shut_s2_reg;
  logic rstn_s1_reg, rstn_s2_reg;
  logic sel_s1_reg, sel_s2_reg;
  logic sck_s1_reg, sck_s2_reg;
  logic sin_s1_reg, sin_s2_reg;

  always_ff @(posedge link.pixel_clock) begin
    if (reset) begin
      shut_s1_reg <= 1'b0;
      shut_s2_reg <= 1'b0;
      rstn_s1_reg <= 1'b0;
      rstn_s2_reg <= 1'b0;
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      sck_s1_reg <= 1'b0;
      sck_s2_reg <= 1'b0;
      sin_s1_reg <= 1'b0;
      sin_s2_reg <= 1'b0;
    end else begin
      shut_s1_reg <= link.shutdown;
      shut_s2_reg <= shut_s1_reg;
      rstn_s1_reg <= link.module_reset_n;
      rstn_s2_reg <= rstn_s1_reg;
      sel_s1_reg <= link.serial_select_n;
      sel_s2_reg <= sel_s1_reg;
      sck_s1_reg <= link.serial_clock;
      sck_s2_reg <= sck_s1_reg;
      sin_s1_reg <= link.serial_input;
      sin_s2_reg <= sin_s1_reg;
    end
  end

  // The module reset pin clears everything past the synchronisers
  logic local_reset;
  assign local_reset = reset || !rstn_s2_reg;

  display_state_t disp_reg, disp_next;
  logic [FW-1:0] falls_reg, falls_next;
  logic vs_prev_reg, vs_fall;
  logic show, show_next;
  logic sel_prev_reg, sck_prev_reg;
  logic [BW-1:0] bits_reg, bits_next;
  logic [PB:0] shift_reg, shift_next;
  logic valid_next, flag_next;
  logic [PB-1:0] payload_next;
  logic [CB-1:0] red_next, green_next, blue_next;
  logic black_next, white_next;

  assign vs_fall = vs_prev_reg && !link.vertical_sync_pulse_n;
  assign show = disp_reg == D_ON || disp_reg == D_ARMED;

  always_comb begin
    disp_next = disp_reg;
    falls_next = falls_reg;
    unique case (disp_reg)
      D_ON: begin
        if (shut_s2_reg) begin
          disp_next = D_ARMED;
          falls_next = '0;
        end
      end
      D_ARMED: begin
        if (!shut_s2_reg) begin
          disp_next = D_ON;
        end else if (vs_fall) begin
          falls_next = FW'(falls_reg + 1'b1);
          if (falls_next == FW'(OFF_FALLS)) begin
            disp_next = D_OFF;
          end
        end
      end
      D_OFF: begin
        if (!shut_s2_reg) begin
          disp_next = D_WAKE;
          falls_next = '0;
        end
      end
      D_WAKE: begin
        if (shut_s2_reg) begin
          disp_next = D_OFF;
        end else if (vs_fall) begin
          falls_next = FW'(falls_reg + 1'b1);
          if (falls_next == FW'(ON_FALLS)) begin
            disp_next = D_ON;
          end
        end
      end
    endcase
    show_next = disp_next == D_ON || disp_next == D_ARMED;
  end

  // A blanked panel shows black whatever the host sends
  always_comb begin
    red_next = lcd_link_pkg::DARKEST_LEVEL;
    green_next = lcd_link_pkg::DARKEST_LEVEL;
    blue_next = lcd_link_pkg::DARKEST_LEVEL;
    if (show) begin
      red_next = link.pixel_data[lcd_link_pkg::RED_LSB +: CB];
      green_next = link.pixel_data[lcd_link_pkg::GREEN_LSB +: CB];
      blue_next = link.pixel_data[lcd_link_pkg::BLUE_LSB +: CB];
    end
    black_next = !show ||
      all_channels(link.pixel_data, lcd_link_pkg::DARKEST_LEVEL);
    white_next = show &&
      all_channels(link.pixel_data, lcd_link_pkg::BRIGHTEST_LEVEL);
  end

  always_comb begin
    bits_next = bits_reg;
    shift_next = shift_reg;
    if (sel_prev_reg && !sel_s2_reg) begin
      bits_next = '0;
      shift_next = '0;
    end else if (!sel_s2_reg && sck_s2_reg && !sck_prev_reg) begin
      shift_next = {shift_reg[PB-1:0], sin_s2_reg};
      if (bits_reg != OVER_COUNT) begin
        bits_next = BW'(bits_reg + 1'b1);
      end
    end
    // Short or long words die here without touching the outputs
    valid_next = !sel_prev_reg && sel_s2_reg &&
      bits_reg == FULL_COUNT;
    flag_next = valid_next ? shift_reg[PB] : setup_command_data_flag;
    payload_next = valid_next ? shift_reg[PB-1:0] : setup_payload;
  end

  always_ff @(posedge link.pixel_clock) begin
    if (local_reset) begin
      disp_reg <= D_WAKE;
      falls_reg <= '0;
      vs_prev_reg <= 1'b1;
      display_on <= 1'b0;
      red_out <= lcd_link_pkg::DARKEST_LEVEL;
      green_out <= lcd_link_pkg::DARKEST_LEVEL;
      blue_out <= lcd_link_pkg::DARKEST_LEVEL;
      pixel_black <= 1'b1;
      pixel_white <= 1'b0;
      sel_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
      bits_reg <= '0;
      shift_reg <= '0;
      setup_valid <= 1'b0;
      setup_command_data_flag <= 1'b0;
      setup_payload <= '0;
    end else begin
      disp_reg <= disp_next;
      falls_reg <= falls_next;
      vs_prev_reg <= link.vertical_sync_pulse_n;
      display_on <= show_next;
      red_out <= red_next;
      green_out <= green_next;
      blue_out <= blue_next;
      pixel_black <= black_next;
      pixel_white <= white_next;
      sel_prev_reg <= sel_s2_reg;
      sck_prev_reg <= sck_s2_reg;
      bits_reg <= bits_next;
      shift_reg <= shift_next;
      setup_valid <= valid_next;
      setup_command_data_flag <= flag_next;
      setup_payload <= payload_next;
    end
  end
endmodule
